/* hqf_pkg.sv */
package hqf_pkg;
   // Frame word layout
   localparam int HQF_LEN_W       = 11;
   localparam int HQF_MAX_BYTES   = 1916;
   localparam int HQF_ADDR_BYTES  = 6;
   localparam int HQF_TYPE_HI_IDX = 12;
   localparam int HQF_TYPE_LO_IDX = 13;
   localparam int HQF_CRC_BYTES   = 4;
   localparam logic [15:0] HQF_ETHERTYPE_MIN = 16'h05dc; // 1500
   localparam logic [10:0] HQF_OVERSIZE_LEN  = 11'h5ee;  // 1518
   // Status word bit positions
   localparam int HQF_ST_VALID = 15;
   localparam int HQF_ST_PORT  = 8;
   localparam int HQF_ST_BCAST = 7;
   localparam int HQF_ST_MCAST = 6;
   localparam int HQF_ST_UCAST = 5;
   localparam int HQF_ST_ETYPE = 3;
   localparam int HQF_ST_LONG  = 2;
   localparam int HQF_ST_RUNT  = 1;
   localparam int HQF_ST_CRC   = 0;
   // Transmit control word fields
   localparam int HQF_TC_IRQ  = 15;
   localparam int HQF_TC_PORT = 8;
   localparam logic [15:0] HQF_TC_MASK = 16'h833f;
   // Register byte offsets
   localparam logic [7:0] HQF_REG_CTRL   = 8'h00;
   localparam logic [7:0] HQF_REG_RXSTAT = 8'h04;
   localparam logic [7:0] HQF_REG_RXLEN  = 8'h08;
   localparam logic [7:0] HQF_REG_TXCTRL = 8'h0c;
   localparam logic [7:0] HQF_REG_TXLEN  = 8'h10;
   localparam int HQF_CTRL_STRIP = 0;
   localparam int HQF_CTRL_PASS  = 1;
   localparam logic [1:0] HQF_CTRL_RESET = 2'h0;
   localparam logic [1:0] HQF_RESP_OKAY  = 2'h0;
   localparam logic [1:0] HQF_RESP_DECERR = 2'h3;
   // Transmit sequencer
   typedef enum logic [2:0] {
      HQF_TX_CTRL = 3'b000,
      HQF_TX_CNT  = 3'b001,
      HQF_TX_WORD = 3'b010,
      HQF_TX_LO   = 3'b011,
      HQF_TX_HI   = 3'b100
   } hqf_tx_type;
endpackage : hqf_pkg

/* hqf_host_queue_frame_format.sv */
`timescale 1ns/1ps
`default_nettype none
module hqf_host_queue_frame_format
   import hqf_pkg::*;
#(
   parameter int MAX_BYTES = HQF_MAX_BYTES
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Transmit queue words from host
   input  wire logic [15:0] txWord,
   input  wire logic        txValid,
   output logic             txReady,
   // Transmit bytes to switch
   output logic [7:0]       macByte,
   output logic             macValid,
   input  wire logic        macReady,
   output logic             macLast,
   output logic [1:0]       tx_destination_ports,
   output logic [5:0]       tx_frame_tag,
   output logic             tx_completion_irq_request,
   output logic [10:0]      tx_frame_length,
   // Receive bytes from switch
   input  wire logic [7:0]  rxByte,
   input  wire logic        rxByteValid,
   input  wire logic        rxByteLast,
   output logic             rxReady,
   input  wire logic [1:0]  rx_ingress_port,
   input  wire logic        rxCrcBad,
   input  wire logic        rxCollision,
   // Receive queue words to host
   output logic [15:0]      rqWord,
   output logic             rqValid,
   input  wire logic        rqReady,
   output logic             rqLast
);

   //-------------------------------------------------------------
   // Register bus
   //-------------------------------------------------------------
   logic [1:0]  ctrl;
   logic [15:0] rx_frame_status_reg;
   logic [10:0] rx_frame_length;
   logic [15:0] txCtrlWord;
   logic        held;
   wire         wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire         rdTake = s_axi_arvalid & ~s_axi_rvalid;
   wire         wrCtrl = s_axi_awaddr == HQF_REG_CTRL;
   wire [31:0]  rdMux;
   wire         rdHit;

   assign s_axi_awready = wrTake;
   assign s_axi_wready  = wrTake;
   assign s_axi_arready = rdTake;
   // Valid bit is stored status bit 15, set and cleared together with held
   assign rdMux = (s_axi_araddr == HQF_REG_CTRL)   ? {30'h0, ctrl} :
                  (s_axi_araddr == HQF_REG_RXSTAT) ? {16'h0, rx_frame_status_reg} :
                  (s_axi_araddr == HQF_REG_RXLEN)  ? {21'h0, rx_frame_length} :
                  (s_axi_araddr == HQF_REG_TXCTRL) ? {16'h0, txCtrlWord} :
                  (s_axi_araddr == HQF_REG_TXLEN)  ? {21'h0, tx_frame_length} :
                  32'h0;
   assign rdHit = (s_axi_araddr == HQF_REG_CTRL) | (s_axi_araddr == HQF_REG_RXSTAT)
                | (s_axi_araddr == HQF_REG_RXLEN) | (s_axi_araddr == HQF_REG_TXCTRL)
                | (s_axi_araddr == HQF_REG_TXLEN);

   // Write channel and response
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl         <= HQF_CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= HQF_RESP_OKAY;
      end else begin
         if (wrTake && wrCtrl && s_axi_wstrb[0])
            ctrl <= s_axi_wdata[1:0];
         if (wrTake) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrCtrl ? HQF_RESP_OKAY : HQF_RESP_DECERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= HQF_RESP_OKAY;
      end else if (rdTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdMux;
         s_axi_rresp  <= rdHit ? HQF_RESP_OKAY : HQF_RESP_DECERR;
      end else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   //-------------------------------------------------------------
   // Transmit framer
   //-------------------------------------------------------------
   hqf_tx_type  txState;
   logic [15:0] txHold;
   logic [10:0] txLeft;
   wire         txTake = txValid & txReady;
   wire         byteGo = macValid & macReady;

   assign txReady  = (txState == HQF_TX_CTRL) | (txState == HQF_TX_CNT)
                   | (txState == HQF_TX_WORD);
   assign macValid = (txState == HQF_TX_LO) | (txState == HQF_TX_HI);
   // Bytes leave untouched; addresses and type word are opaque
   assign macByte  = (txState == HQF_TX_HI) ? txHold[15:8] : txHold[7:0];
   assign macLast  = macValid & (txLeft == 11'h1);
   assign tx_completion_irq_request = txCtrlWord[HQF_TC_IRQ];
   assign tx_destination_ports      = txCtrlWord[HQF_TC_PORT+1:HQF_TC_PORT];
   assign tx_frame_tag              = txCtrlWord[5:0];

   // Control word, count word, then data words in order
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         txState         <= HQF_TX_CTRL;
         txHold          <= 16'h0;
         txLeft          <= 11'h0;
         txCtrlWord      <= 16'h0;
         tx_frame_length <= 11'h0;
      end else begin
         case (txState)
            HQF_TX_CTRL: if (txTake) begin
               txCtrlWord <= txWord & HQF_TC_MASK;
               txState    <= HQF_TX_CNT;
            end
            HQF_TX_CNT: if (txTake) begin
               tx_frame_length <= txWord[HQF_LEN_W-1:0];
               txLeft          <= txWord[HQF_LEN_W-1:0];
               // Zero length is illegal; skip data rather than hang
               txState <= (txWord[HQF_LEN_W-1:0] == 11'h0) ? HQF_TX_CTRL : HQF_TX_WORD;
            end
            HQF_TX_WORD: if (txTake) begin
               txHold  <= txWord;
               txState <= HQF_TX_LO;
            end
            HQF_TX_LO: if (byteGo) begin
               txLeft  <= txLeft - 11'h1;
               txState <= (txLeft == 11'h1) ? HQF_TX_CTRL : HQF_TX_HI;
            end
            HQF_TX_HI: if (byteGo) begin
               txLeft  <= txLeft - 11'h1;
               txState <= (txLeft == 11'h1) ? HQF_TX_CTRL : HQF_TX_WORD;
            end
            default: txState <= HQF_TX_CTRL;
         endcase
      end
   end

   //-------------------------------------------------------------
   // Receive capture
   //-------------------------------------------------------------
   logic [7:0]  rxMem [MAX_BYTES];
   logic [10:0] rxCnt;
   logic        daGroup;
   logic        daAllOnes;
   logic [15:0] lenType;
   logic [10:0] rdPos;
   wire         rxGo     = rxByteValid & rxReady;
   wire  [10:0] fullLen  = rxCnt + 11'h1;
   wire  [10:0] storeLen = (ctrl[HQF_CTRL_STRIP] && fullLen >= 11'(HQF_CRC_BYTES))
                         ? fullLen - 11'(HQF_CRC_BYTES) : fullLen;
   wire         isLong   = fullLen > HQF_OVERSIZE_LEN;
   wire         isBad    = rxCrcBad | isLong;
   wire         keep     = ~isBad | ctrl[HQF_CTRL_PASS];
   wire         bcast    = daAllOnes & (rxCnt >= 11'(HQF_ADDR_BYTES - 1))
                         & (rxCnt != 11'(HQF_ADDR_BYTES - 1) | rxByte == 8'hff);
   wire         runtLen  = fullLen <= 11'(HQF_TYPE_LO_IDX);
   wire  [7:0]  typeLo   = (rxCnt == 11'(HQF_TYPE_LO_IDX)) ? rxByte : lenType[7:0];
   wire  [15:0] nextStatus;

   assign rxReady = ~held;
   // Classification latched with the frame, so it stays with it
   assign nextStatus = {1'b1, 5'h0, rx_ingress_port,
                        bcast,
                        daGroup,
                        ~daGroup,
                        1'b0,
                        ~runtLen & ({lenType[15:8], typeLo} > HQF_ETHERTYPE_MIN),
                        isLong,
                        rxCollision,
                        rxCrcBad};

   // Byte store; excess bytes beyond the buffer are counted only
   always_ff @(posedge ref_clk) begin
      if (rxGo && rxCnt < 11'(MAX_BYTES))
         rxMem[rxCnt] <= rxByte;
   end

   // Frame accounting and head status
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rxCnt               <= 11'h0;
         daGroup             <= 1'b0;
         daAllOnes           <= 1'b0;
         lenType             <= 16'h0;
         held                <= 1'b0;
         rx_frame_status_reg <= 16'h0;
         rx_frame_length     <= 11'h0;
      end else begin
         if (rxGo) begin
            if (rxCnt == 11'h0) begin
               daGroup   <= rxByte[0];
               daAllOnes <= rxByte == 8'hff;
            end else if (rxCnt < 11'(HQF_ADDR_BYTES))
               daAllOnes <= daAllOnes & (rxByte == 8'hff);
            if (rxCnt == 11'(HQF_TYPE_HI_IDX))
               lenType[15:8] <= rxByte;
            if (rxCnt == 11'(HQF_TYPE_LO_IDX))
               lenType[7:0] <= rxByte;
            rxCnt <= (rxCnt == 11'h7ff) ? rxCnt : rxCnt + 11'h1;
            if (rxByteLast) begin
               rxCnt <= 11'h0;
               if (keep) begin
                  held                <= 1'b1;
                  rx_frame_status_reg <= nextStatus;
                  rx_frame_length     <= storeLen;
               end
            end
         end
         // Frame leaves the head once its last word is taken
         if (rqValid && rqReady && rqLast) begin
            held                <= 1'b0;
            rx_frame_status_reg <= 16'h0;
         end
      end
   end

   //-------------------------------------------------------------
   // Receive readout
   //-------------------------------------------------------------
   wire [10:0] dataWords = 11'((rx_frame_length + 11'h1) >> 1);
   wire [10:0] byteIdx   = 11'((rdPos - 11'h2) << 1);
   wire [10:0] hiIdx     = byteIdx + 11'h1;
   wire [7:0]  loByte    = (byteIdx < 11'(MAX_BYTES)) ? rxMem[byteIdx] : 8'h0;
   wire [7:0]  hiByte    = (hiIdx < 11'(MAX_BYTES) && hiIdx < rx_frame_length)
                         ? rxMem[hiIdx] : 8'h0;

   assign rqValid = held;
   assign rqLast  = held & (rdPos == dataWords + 11'h1);
   // Status at offset 0, count at 2, data from 4 onward
   assign rqWord  = (rdPos == 11'h0) ? rx_frame_status_reg :
                    (rdPos == 11'h1) ? {5'h0, rx_frame_length} :
                    {hiByte, loByte};

   // Word pointer through the held frame
   always_ff @(posedge ref_clk) begin
      if (reset)
         rdPos <= 11'h0;
      else if (rqValid && rqReady)
         rdPos <= rqLast ? 11'h0 : rdPos + 11'h1;
   end

   //-------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------
   property p_len_low;
      @(posedge ref_clk) disable iff (reset)
      (txState == HQF_TX_CNT && txTake) |=> tx_frame_length == $past(txWord[10:0]);
   endproperty
   a_len_low: assert property (p_len_low) else $error("tx length not captured");

   property p_src_pass;
      @(posedge ref_clk) disable iff (reset)
      (txState == HQF_TX_WORD && txTake) |=> macByte == $past(txWord[7:0]);
   endproperty
   a_src_pass: assert property (p_src_pass) else $error("tx byte altered");

   property p_byte_count;
      @(posedge ref_clk) disable iff (reset)
      (txState == HQF_TX_CNT && txTake && txWord[10:0] == 11'h2)
         |=> ##[1:200] (macLast && byteGo);
   endproperty
   a_byte_count: assert property (p_byte_count) else $error("tx length not honoured");

   property p_valid_bit;
      @(posedge ref_clk) disable iff (reset)
      rx_frame_status_reg[HQF_ST_VALID] == held;
   endproperty
   a_valid_bit: assert property (p_valid_bit) else $error("valid bit mismatch");

   property p_mcast_bcast;
      @(posedge ref_clk) disable iff (reset)
      rx_frame_status_reg[HQF_ST_BCAST] |-> rx_frame_status_reg[HQF_ST_MCAST];
   endproperty
   a_mcast_bcast: assert property (p_mcast_bcast) else $error("broadcast not multicast");

   property p_ucast;
      @(posedge ref_clk) disable iff (reset)
      held |-> rx_frame_status_reg[HQF_ST_UCAST] == !rxMem[0][0];
   endproperty
   a_ucast: assert property (p_ucast) else $error("unicast flag wrong");

   property p_bad_drop;
      @(posedge ref_clk) disable iff (reset)
      (rxGo && rxByteLast && rxCrcBad && !ctrl[HQF_CTRL_PASS]) |=> !held;
   endproperty
   a_bad_drop: assert property (p_bad_drop) else $error("bad frame kept");

   property p_strip;
      @(posedge ref_clk) disable iff (reset)
      (rxGo && rxByteLast && keep && ctrl[HQF_CTRL_STRIP] && fullLen > 11'h4)
         |=> rx_frame_length == $past(fullLen) - 11'h4;
   endproperty
   a_strip: assert property (p_strip) else $error("crc bytes not stripped");

   property p_head_first;
      @(posedge ref_clk) disable iff (reset)
      (rqValid && rdPos == 11'h0) |-> rqWord == rx_frame_status_reg;
   endproperty
   a_head_first: assert property (p_head_first) else $error("status not first");

   property p_release;
      @(posedge ref_clk) disable iff (reset)
      (rqValid && rqReady && rqLast) |=> !held && rdPos == 11'h0;
   endproperty
   a_release: assert property (p_release) else $error("head not released");

   c_tx_frame: cover property (@(posedge ref_clk) disable iff (reset) macLast && byteGo);
   c_rx_held: cover property (@(posedge ref_clk) disable iff (reset) $rose(held));
   c_rx_read: cover property (@(posedge ref_clk) disable iff (reset) rqLast && rqReady);
   c_axi_rd: cover property (@(posedge ref_clk) disable iff (reset) s_axi_rvalid && s_axi_rready);

endmodule : hqf_host_queue_frame_format
`default_nettype wire

/* hqf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host processor side of the packet queues
// ----------------------------------------
module hqf_host_model
   import hqf_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Transmit queue writes
   output logic [15:0]      txWord,
   output logic             txValid,
   input  wire logic        txReady,
   // Receive queue reads
   output logic             rqReady
);
   logic [15:0] pend[$];
   // Bench queues whole frames, control word first
   task automatic push(input logic [15:0] w);
      pend.push_back(w);
   endtask : push
   // Random pacing; an idle bus shows inverted data so nothing stale is taken
   always @(posedge ref_clk) begin
      if (reset) begin
         txValid <= 1'b0;
         txWord  <= 16'h0000;
         rqReady <= 1'b0;
      end else begin
         rqReady <= ($urandom_range(3) != 0);
         if (!txValid || txReady) begin
            if (pend.size() != 0 && $urandom_range(3) != 0) begin
               txWord  <= pend.pop_front();
               txValid <= 1'b1;
            end else begin
               txValid <= 1'b0;
               txWord  <= ~txWord;
            end
         end
      end
   end
endmodule : hqf_host_model
`default_nettype wire

/* hqf_host_queue_frame_format_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hqf_host_queue_frame_format_tb
   import hqf_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        ref_clk = 1'b0, reset = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rxByte = 8'h00, macByte;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tx_destination_ports, rx_ingress_port = 2'b01;
   logic [15:0] txWord, rqWord;
   logic        txValid, txReady, macValid, macLast, rxReady, rqValid, rqReady, rqLast;
   logic        tx_completion_irq_request;
   logic        macReady = 1'b0, rxByteValid = 1'b0, rxByteLast = 1'b0;
   logic        rxCrcBad = 1'b0, rxCollision = 1'b0;
   logic [5:0]  tx_frame_tag;
   logic [10:0] tx_frame_length;
   logic [7:0]  fb [0:1519];
   logic [16:0] txExp[$];
   logic [32:0] rqExp[$];
   logic [33:0] bExp[$], rExp[$], e;
   int          err_count = 0, samples_checked = 0;

   always #25 ref_clk = ~ref_clk;

   hqf_host_queue_frame_format hqf_host_queue_frame_format_inst (
      .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txWord, .txValid, .txReady,
      .macByte, .macValid, .macReady, .macLast, .tx_destination_ports, .tx_frame_tag,
      .tx_completion_irq_request, .tx_frame_length, .rxByte, .rxByteValid,
      .rxByteLast, .rxReady, .rx_ingress_port, .rxCrcBad, .rxCollision, .rqWord,
      .rqValid, .rqReady, .rqLast);

   hqf_host_model hqf_host_model_inst (
      .ref_clk, .reset, .txWord, .txValid, .txReady, .rqReady);

   // ----------------------------------------
   // Checking and reporting
   // ----------------------------------------
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tmo(input int w);
      if (w >= 4000) begin
         err_count++;
         final_report();
      end
   endtask : tmo

   // Stalling switch side makes the byte stream hold its value
   always @(posedge ref_clk) macReady <= ($urandom_range(2) != 0);

   // Monitor: oldest note against each result as it appears
   always @(posedge ref_clk) begin
      if (!reset) begin
         if (macValid && macReady) begin
            e = (txExp.size() != 0) ? 34'(txExp.pop_front()) : 'x;
            chk("mac byte", e, {macLast, macByte});
         end
         if (rqValid && rqReady) begin
            e = (rqExp.size() != 0) ? 34'(rqExp.pop_front()) : {17'h0, 17'hx};
            chk("rq word", {e[16], e[15:0] | e[32:17]}, {rqLast, rqWord | e[32:17]});
         end
         if (s_axi_bvalid) chk("bresp", bExp.pop_front(), s_axi_bresp);
         if (s_axi_rvalid) chk("rdata", rExp.pop_front(), {s_axi_rresp, s_axi_rdata});
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int w;
      logic aw, wd;
      bExp.push_back(34'(r));
      aw = 1'b1;
      wd = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (w = 0; w < 4000; w++) begin
         @(posedge ref_clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wd && s_axi_wready) begin
            wd = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) break;
      end
      tmo(w);
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int w;
      logic ar;
      rExp.push_back({r, d});
      ar = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (w = 0; w < 4000; w++) begin
         @(posedge ref_clk);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) break;
      end
      tmo(w);
   endtask : axr

   // Byte held until the edge that samples rxReady high
   task automatic rx_frame(input int n, input logic [1:0] p, input logic crc, input logic col);
      int k, w;
      rx_ingress_port <= p;
      rxCrcBad <= crc;
      rxCollision <= col;
      for (k = 0; k < n; k++) begin
         rxByte <= fb[k];
         rxByteValid <= 1'b1;
         rxByteLast <= (k == n - 1);
         for (w = 0; w < 4000; w++) begin
            @(posedge ref_clk);
            if (rxReady) break;
         end
         tmo(w);
      end
      rxByteValid <= 1'b0;
      rxByteLast <= 1'b0;
      rxByte <= ~fb[n - 1];
   endtask : rx_frame

   task automatic waitq;
      int w;
      for (w = 0; w < 4000 && (txExp.size() != 0 || rqExp.size() != 0); w++) @(posedge ref_clk);
      tmo(w);
   endtask : waitq

   function automatic logic [15:0] rx_status(input int n, input logic [1:0] p,
                                             input logic crc, input logic col);
      logic bc, mc, et;
      bc = ({fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} == 48'hffffffffffff);
      mc = fb[0][0];
      et = (n > 13) && ({fb[12], fb[13]} > HQF_ETHERTYPE_MIN);
      return {1'b1, 5'h00, p, bc, mc, !mc, 1'b0, et, n > int'(HQF_OVERSIZE_LEN), col, crc};
   endfunction : rx_status

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (100000) @(posedge ref_clk);
      err_count++;
      final_report();
   end

   initial begin
      int i, k, n, L;
      logic [15:0] c;
      logic [1:0] p;
      logic crc, col;
      void'($urandom(11530));
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      // Reset values, unmapped and read-only places
      axr(HQF_REG_CTRL, 32'h0, HQF_RESP_OKAY);
      axr(8'h14, 32'h0, HQF_RESP_DECERR);
      axw(HQF_REG_RXSTAT, 32'h1, HQF_RESP_DECERR);
      axr(HQF_REG_RXSTAT, 32'h0, HQF_RESP_OKAY);
      // Transmit: port selections 1 to 3 (never 0), odd, even and one-byte lengths
      for (i = 0; i < 4; i++) begin
         n = (i == 0) ? 15 : (i == 1) ? 2 : (i == 2) ? 1 : 60;
         c = (i == 0) ? 16'hffff : {6'h00, 2'(i), 2'b00, 6'(i * 5)};
         for (k = 0; k <= n; k++) fb[k] = 8'($urandom);
         hqf_host_model_inst.push(c);
         hqf_host_model_inst.push({5'h00, 11'(n)});
         for (k = 0; k < n; k += 2) hqf_host_model_inst.push({fb[k + 1], fb[k]});
         for (k = 0; k < n; k++) txExp.push_back({k == n - 1, fb[k]});
         waitq();
         chk("tx fields", {c[15], c[9:8], c[5:0], 11'(n)}, {tx_completion_irq_request,
             tx_destination_ports, tx_frame_tag, tx_frame_length});
         axr(HQF_REG_TXCTRL, {16'h0000, c & HQF_TC_MASK}, HQF_RESP_OKAY);
         axr(HQF_REG_TXLEN, 32'(n), HQF_RESP_OKAY);
      end
      // Receive: address classes, type, oversize, dropped and passed bad frames
      for (i = 0; i < 6; i++) begin
         n = (i == 0) ? 64 : (i == 1) ? 61 : (i == 2) ? 14 : (i == 3) ? 40 : (i == 4) ? 70 : 1520;
         p = (i % 2 != 0) ? 2'b10 : 2'b01;
         crc = (i == 3 || i == 4);
         col = (i == 1);
         axw(HQF_REG_CTRL, (i == 4) ? 32'h3 : (i == 5) ? 32'h2 : 32'h0, HQF_RESP_OKAY);
         for (k = 0; k < n; k++) fb[k] = 8'($urandom);
         if (i == 0) for (k = 0; k < 6; k++) fb[k] = 8'hff;
         else fb[0] = {fb[0][7:1], i == 1};
         if (i < 3) {fb[12], fb[13]} = (i == 0) ? 16'h0800 : (i == 1) ? 16'h05dc : 16'h05dd;
         L = (i == 4) ? n - 4 : n;
         if (i != 3) begin
            rqExp.push_back({17'h0, rx_status(n, p, crc, col)});
            rqExp.push_back({16'h0, L == 0, 5'h00, 11'(L)});
            for (k = 0; k < L; k += 2)
               rqExp.push_back({(k + 1 < L) ? 16'h0 : 16'hff00, k + 2 >= L, fb[k + 1], fb[k]});
         end
         rx_frame(n, p, crc, col);
         waitq();
      end
      axr(HQF_REG_RXSTAT, 32'h0, HQF_RESP_OKAY);
      @(posedge ref_clk);
      final_report();
   end
endmodule : hqf_host_queue_frame_format_tb
`default_nettype wire
